// ===== sensor_cfg_pkg.sv
// constants of the sensor support configuration slice
// assumes an 8-bit register address and 16-bit register words
package sensor_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  localparam logic [7:0] ADDR_BIAS_REF = 8'h46;
  localparam logic [7:0] ADDR_CHARGE_PUMP = 8'h48;
  localparam logic [7:0] ADDR_SPARE_A = 8'h50;
  localparam logic [7:0] ADDR_SPARE_B = 8'h51;
  localparam logic [7:0] ADDR_THERM_CTRL = 8'h60;
  localparam logic [7:0] ADDR_THERM_READ = 8'h61;
  localparam logic [7:0] ADDR_SER_POWER = 8'h70;
  localparam logic [7:0] ADDR_DARK_CAL = 8'h80;

  localparam logic [15:0] RST_BIAS_REF = 16'h8888;
  localparam logic [15:0] RST_CHARGE_PUMP = 16'h1200;
  localparam logic [15:0] RST_SPARE_A = 16'h0000;
  localparam logic [15:0] RST_SPARE_B = 16'h0000;
  localparam logic [15:0] RST_THERM_CTRL = 16'h0000;
  localparam logic [15:0] RST_SER_POWER = 16'h0000;
  localparam logic [15:0] RST_DARK_CAL = 16'h4008;
  localparam logic [15:0] RST_READ_DATA = 16'h0000;
  localparam logic [7:0] RST_THERM_CODE = 8'h00;
  localparam logic [7:0] RST_DARK_COUNT = 8'h01;

  // serializer power control bits
  localparam int SER_CLK_BIT = 0;
  localparam int SER_SYNC_BIT = 1;
  localparam int SER_DATA_BIT = 2;
  localparam int DATA_LANES = 4;

  // charge pump fields
  localparam int PD_PUMP_EN_BIT = 0;
  localparam int FD_PUMP_EN_BIT = 1;
  localparam int PD_TRIM_LSB = 8;
  localparam int FD_TRIM_LSB = 12;
  localparam int TRIM_W = 3;

  localparam int DIODE_EN_BIT = 0;

  // dark level calibration fields
  localparam int DARK_TARGET_LSB = 0;
  localparam int DARK_TARGET_W = 8;
  localparam int DARK_EXP_LSB = 8;
  localparam int DARK_EXP_W = 3;
  localparam int DARK_COUNT_W = 8;

  localparam int THERM_CODE_W = 8;
endpackage

// ===== cfg_word.sv
// one writable configuration word with a fixed reset value
// assumes write enable and data synchronous to sys_clk
`timescale 1ns/10ps
`default_nettype none
module cfg_word #(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [15:0] wdata,
  output logic [15:0] q
);
  logic [15:0] word_q;
  logic [15:0] word_d;

  always_comb begin
    word_d = word_q;
    if (wr_en) begin
      word_d = wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      word_q <= RESET_VAL;
    end else begin
      word_q <= word_d;
    end
  end

  assign q = word_q;
endmodule
`default_nettype wire

// ===== sensor_support_config_regs.sv
// configuration slice: bias, charge pumps, spares, thermal diode,
// serializer power and the first dark level calibration word
// assumes the register port is synchronous to sys_clk, one access per cycle
//
// Summary of operation
// - serializer power bit 0 enables the serial clock output driver.
// - serializer power bit 1 powers the sync output channel.
// - serializer power bit 2 powers all four data lanes together.
// - pump bit 0 enables transfer pump; bits 10:8 are its trim.
// - pump bit 1 enables diffusion pump; bits 14:12 are its trim.
// - thermal control bit 0 enables the diode; off after reset.
// - dark calibration bits 7:0 give the target dark level, reset 0x08.
// - dark samples averaged equal two to the power of bits 10:8.
`timescale 1ns/10ps
`default_nettype none
module sensor_support_config_regs (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [sensor_cfg_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic [sensor_cfg_pkg::DATA_W-1:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [sensor_cfg_pkg::DATA_W-1:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic [sensor_cfg_pkg::THERM_CODE_W-1:0] therm_code,
  output logic [15:0] bias_ref_word,
  output logic clk_out_en,
  output logic sync_out_en,
  output logic [sensor_cfg_pkg::DATA_LANES-1:0] data_lane_en,
  output logic pd_pump_en,
  output logic [sensor_cfg_pkg::TRIM_W-1:0] pd_pump_trim,
  output logic fd_pump_en,
  output logic [sensor_cfg_pkg::TRIM_W-1:0] fd_pump_trim,
  output logic therm_diode_en,
  output logic [sensor_cfg_pkg::DARK_TARGET_W-1:0] dark_target,
  output logic [sensor_cfg_pkg::DARK_EXP_W-1:0] dark_exp,
  output logic [sensor_cfg_pkg::DARK_COUNT_W-1:0] dark_count
);
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction

  function automatic logic [7:0] sample_count(input logic [2:0] expo);
    sample_count = 8'h01 << expo;
  endfunction

  logic [15:0] bias_w;
  logic [15:0] pump_w;
  logic [15:0] spare_a_w;
  logic [15:0] spare_b_w;
  logic [15:0] therm_w;
  logic [15:0] ser_w;
  logic [15:0] dark_w;

  // writable words; reserved bits are stored as written
  cfg_word #(.RESET_VAL(sensor_cfg_pkg::RST_BIAS_REF)) u_bias (
    .sys_clk(sys_clk), .nrst(nrst), .wdata(cfg_wdata), .q(bias_w),
    .wr_en(cfg_wr && hit(cfg_addr, sensor_cfg_pkg::ADDR_BIAS_REF)));
  cfg_word #(.RESET_VAL(sensor_cfg_pkg::RST_CHARGE_PUMP)) u_pump (
    .sys_clk(sys_clk), .nrst(nrst), .wdata(cfg_wdata), .q(pump_w),
    .wr_en(cfg_wr && hit(cfg_addr, sensor_cfg_pkg::ADDR_CHARGE_PUMP)));
  cfg_word #(.RESET_VAL(sensor_cfg_pkg::RST_SPARE_A)) u_spare_a (
    .sys_clk(sys_clk), .nrst(nrst), .wdata(cfg_wdata), .q(spare_a_w),
    .wr_en(cfg_wr && hit(cfg_addr, sensor_cfg_pkg::ADDR_SPARE_A)));
  cfg_word #(.RESET_VAL(sensor_cfg_pkg::RST_SPARE_B)) u_spare_b (
    .sys_clk(sys_clk), .nrst(nrst), .wdata(cfg_wdata), .q(spare_b_w),
    .wr_en(cfg_wr && hit(cfg_addr, sensor_cfg_pkg::ADDR_SPARE_B)));
  cfg_word #(.RESET_VAL(sensor_cfg_pkg::RST_THERM_CTRL)) u_therm (
    .sys_clk(sys_clk), .nrst(nrst), .wdata(cfg_wdata), .q(therm_w),
    .wr_en(cfg_wr && hit(cfg_addr, sensor_cfg_pkg::ADDR_THERM_CTRL)));
  cfg_word #(.RESET_VAL(sensor_cfg_pkg::RST_SER_POWER)) u_ser (
    .sys_clk(sys_clk), .nrst(nrst), .wdata(cfg_wdata), .q(ser_w),
    .wr_en(cfg_wr && hit(cfg_addr, sensor_cfg_pkg::ADDR_SER_POWER)));
  cfg_word #(.RESET_VAL(sensor_cfg_pkg::RST_DARK_CAL)) u_dark (
    .sys_clk(sys_clk), .nrst(nrst), .wdata(cfg_wdata), .q(dark_w),
    .wr_en(cfg_wr && hit(cfg_addr, sensor_cfg_pkg::ADDR_DARK_CAL)));

  // temperature code, read data and sample count
  logic [7:0] therm_q;
  logic [7:0] therm_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [7:0] count_q;
  logic [7:0] count_d;

  always_comb begin
    therm_d = therm_code;
    count_d = sample_count(dark_exp);
    rvalid_d = cfg_rd;
    rdata_d = rdata_q;
    if (cfg_rd) begin
      if (hit(cfg_addr, sensor_cfg_pkg::ADDR_BIAS_REF)) begin
        rdata_d = bias_w;
      end else if (hit(cfg_addr, sensor_cfg_pkg::ADDR_CHARGE_PUMP)) begin
        rdata_d = pump_w;
      end else if (hit(cfg_addr, sensor_cfg_pkg::ADDR_SPARE_A)) begin
        rdata_d = spare_a_w;
      end else if (hit(cfg_addr, sensor_cfg_pkg::ADDR_SPARE_B)) begin
        rdata_d = spare_b_w;
      end else if (hit(cfg_addr, sensor_cfg_pkg::ADDR_THERM_CTRL)) begin
        rdata_d = therm_w;
      end else if (hit(cfg_addr, sensor_cfg_pkg::ADDR_THERM_READ)) begin
        rdata_d = {8'h00, therm_q};
      end else if (hit(cfg_addr, sensor_cfg_pkg::ADDR_SER_POWER)) begin
        rdata_d = ser_w;
      end else if (hit(cfg_addr, sensor_cfg_pkg::ADDR_DARK_CAL)) begin
        rdata_d = dark_w;
      end else begin
        rdata_d = 16'h0000;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      therm_q <= sensor_cfg_pkg::RST_THERM_CODE;
      rdata_q <= sensor_cfg_pkg::RST_READ_DATA;
      rvalid_q <= 1'b0;
      count_q <= sensor_cfg_pkg::RST_DARK_COUNT;
    end else begin
      therm_q <= therm_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      count_q <= count_d;
    end
  end

  assign cfg_rdata = rdata_q;
  assign cfg_rvalid = rvalid_q;
  assign bias_ref_word = bias_w;
  assign clk_out_en = ser_w[sensor_cfg_pkg::SER_CLK_BIT];
  assign sync_out_en = ser_w[sensor_cfg_pkg::SER_SYNC_BIT];
  assign data_lane_en = {sensor_cfg_pkg::DATA_LANES{ser_w[sensor_cfg_pkg::SER_DATA_BIT]}};
  assign pd_pump_en = pump_w[sensor_cfg_pkg::PD_PUMP_EN_BIT];
  assign pd_pump_trim = pump_w[sensor_cfg_pkg::PD_TRIM_LSB +: sensor_cfg_pkg::TRIM_W];
  assign fd_pump_en = pump_w[sensor_cfg_pkg::FD_PUMP_EN_BIT];
  assign fd_pump_trim = pump_w[sensor_cfg_pkg::FD_TRIM_LSB +: sensor_cfg_pkg::TRIM_W];
  assign therm_diode_en = therm_w[sensor_cfg_pkg::DIODE_EN_BIT];
  assign dark_target = dark_w[sensor_cfg_pkg::DARK_TARGET_LSB +: sensor_cfg_pkg::DARK_TARGET_W];
  assign dark_exp = dark_w[sensor_cfg_pkg::DARK_EXP_LSB +: sensor_cfg_pkg::DARK_EXP_W];
  assign dark_count = count_q;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence wr_to(logic [7:0] a);
    cfg_wr && cfg_addr == a;
  endsequence

  sequence rd_of(logic [7:0] a);
    cfg_rd && cfg_addr == a;
  endsequence

  sequence wr_only(logic [7:0] a);
    cfg_wr && !cfg_rd && cfg_addr == a;
  endsequence

  sequence rd_only(logic [7:0] a);
    cfg_rd && !cfg_wr && cfg_addr == a;
  endsequence

  clk_driver_a: assert property (wr_to(sensor_cfg_pkg::ADDR_SER_POWER) |=>
    clk_out_en == $past(cfg_wdata[0])) else $error("clock driver enable wrong");
  sync_chan_a: assert property (wr_to(sensor_cfg_pkg::ADDR_SER_POWER) |=>
    sync_out_en == $past(cfg_wdata[1])) else $error("sync channel enable wrong");
  data_lanes_a: assert property (wr_to(sensor_cfg_pkg::ADDR_SER_POWER) |=>
    data_lane_en == {4{$past(cfg_wdata[2])}}) else $error("data lanes not gated together");
  pd_pump_a: assert property (wr_to(sensor_cfg_pkg::ADDR_CHARGE_PUMP) |=>
    pd_pump_en == $past(cfg_wdata[0]) && pd_pump_trim == $past(cfg_wdata[10:8]))
    else $error("transfer pump control wrong");
  fd_pump_a: assert property (wr_to(sensor_cfg_pkg::ADDR_CHARGE_PUMP) |=>
    fd_pump_en == $past(cfg_wdata[1]) && fd_pump_trim == $past(cfg_wdata[14:12]))
    else $error("diffusion pump control wrong");
  diode_en_a: assert property (wr_to(sensor_cfg_pkg::ADDR_THERM_CTRL) |=>
    therm_diode_en == $past(cfg_wdata[0])) else $error("diode enable wrong");
  dark_target_a: assert property (wr_to(sensor_cfg_pkg::ADDR_DARK_CAL) |=>
    dark_target == $past(cfg_wdata[7:0])) else $error("dark target wrong");
  dark_count_a: assert property (wr_to(sensor_cfg_pkg::ADDR_DARK_CAL) |=> ##1
    dark_count == (8'h01 << $past(cfg_wdata[10:8], 2))) else $error("sample count wrong");
  therm_read_a: assert property (rd_of(sensor_cfg_pkg::ADDR_THERM_READ) |=>
    cfg_rvalid && cfg_rdata == {8'h00, $past(therm_code, 2)})
    else $error("temperature readout wrong");
  spare_back_a: assert property (wr_only(sensor_cfg_pkg::ADDR_SPARE_B) ##1
    rd_only(sensor_cfg_pkg::ADDR_SPARE_B) |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("spare word readback wrong");
  bias_word_a: assert property (wr_to(sensor_cfg_pkg::ADDR_BIAS_REF) |=>
    bias_ref_word == $past(cfg_wdata)) else $error("bias word not stored");
  dark_exp_a: assert property (wr_to(sensor_cfg_pkg::ADDR_DARK_CAL) |=>
    dark_exp == $past(cfg_wdata[10:8])) else $error("sample exponent wrong");

  // readout word ignores writes, no stored word moves
  ro_write_a: assert property (wr_to(sensor_cfg_pkg::ADDR_THERM_READ) |=>
    $stable(bias_w) && $stable(pump_w) && $stable(spare_a_w) && $stable(spare_b_w)
    && $stable(therm_w) && $stable(ser_w) && $stable(dark_w))
    else $error("write to readout word changed a register");

  // static controls only move on a write to their own word
  ser_hold_a: assert property (
    !(cfg_wr && cfg_addr == sensor_cfg_pkg::ADDR_SER_POWER) |=>
    $stable(clk_out_en) && $stable(sync_out_en) && $stable(data_lane_en))
    else $error("serializer power moved without a write");
  pump_hold_a: assert property (
    !(cfg_wr && cfg_addr == sensor_cfg_pkg::ADDR_CHARGE_PUMP) |=>
    $stable(pd_pump_en) && $stable(pd_pump_trim) && $stable(fd_pump_en) && $stable(fd_pump_trim))
    else $error("pump control moved without a write");
  diode_hold_a: assert property (
    !(cfg_wr && cfg_addr == sensor_cfg_pkg::ADDR_THERM_CTRL) |=>
    $stable(therm_diode_en))
    else $error("diode enable moved without a write");
  dark_hold_a: assert property (
    !(cfg_wr && cfg_addr == sensor_cfg_pkg::ADDR_DARK_CAL) |=>
    $stable(dark_target) && $stable(dark_exp))
    else $error("calibration fields moved without a write");
  // count lags the exponent by one register stage
  count_hold_a: assert property (
    !(cfg_wr && cfg_addr == sensor_cfg_pkg::ADDR_DARK_CAL) |=> ##1 $stable(dark_count))
    else $error("sample count moved without a write");
endmodule
`default_nettype wire

// ===== sensor_support_config_regs_test.sv
// self-checking testbench for the sensor support configuration slice
// assumes the design's own assertions run alongside; the bench drives the strobe port
`timescale 1ns/10ps
`default_nettype none
module sensor_support_config_regs_test;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [15:0] cfg_wdata = 16'h0000;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] therm_code = 8'h00;
  logic [15:0] cfg_rdata, bias_ref_word;
  logic cfg_rvalid, clk_out_en, sync_out_en, pd_pump_en, fd_pump_en, therm_diode_en;
  logic [3:0] data_lane_en;
  logic [2:0] pd_pump_trim, fd_pump_trim, dark_exp;
  logic [7:0] dark_target, dark_count;
  int failures = 0;
  int num_checks = 0;

  always #25 sys_clk = ~sys_clk;

  sensor_support_config_regs sensor_support_config_regs_i (
    .sys_clk(sys_clk), .nrst(nrst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .therm_code(therm_code), .bias_ref_word(bias_ref_word), .clk_out_en(clk_out_en),
    .sync_out_en(sync_out_en), .data_lane_en(data_lane_en), .pd_pump_en(pd_pump_en),
    .pd_pump_trim(pd_pump_trim), .fd_pump_en(fd_pump_en), .fd_pump_trim(fd_pump_trim),
    .therm_diode_en(therm_diode_en), .dark_target(dark_target), .dark_exp(dark_exp),
    .dark_count(dark_count)
  );

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    #1;
  endtask

  // read strobe for one cycle, answer checked the cycle after
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string name);
    @(posedge sys_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    #1;
    chk("rvalid", 16'h0001, {15'h0000, cfg_rvalid});
    chk(name, exp, cfg_rdata);
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic t_reset();
    logic [7:0] adr [8] = '{8'h46, 8'h48, 8'h50, 8'h51, 8'h60, 8'h61, 8'h70, 8'h80};
    logic [15:0] dflt [8] = '{16'h8888, 16'h1200, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                              16'h0000, 16'h4008};
    for (int i = 0; i < 8; i++)
      rd(adr[i], dflt[i], "reset word");
    chk("diode", 16'h0000, {15'h0000, therm_diode_en});
    chk("dark target", 16'h0008, {8'h00, dark_target});
    chk("dark count", 16'h0001, {8'h00, dark_count});
    $display("test reset done");
  endtask

  task automatic t_serpow();
    for (int i = 0; i < 8; i++) begin
      wr(8'h70, 16'(i));
      chk("ser power", {10'h000, {4{i[2]}}, i[1], i[0]},
          {10'h000, data_lane_en, sync_out_en, clk_out_en});
    end
    $display("test serializer power done");
  endtask

  task automatic t_pump();
    wr(8'h48, 16'h7301);
    chk("pumps", {8'h00, 3'h7, 1'b0, 3'h3, 1'b1},
        {8'h00, fd_pump_trim, fd_pump_en, pd_pump_trim, pd_pump_en});
    wr(8'h48, 16'h4502);
    chk("pumps", {8'h00, 3'h4, 1'b1, 3'h5, 1'b0},
        {8'h00, fd_pump_trim, fd_pump_en, pd_pump_trim, pd_pump_en});
    $display("test charge pump done");
  endtask

  task automatic t_therm();
    wr(8'h60, 16'h0001);
    chk("diode", 16'h0001, {15'h0000, therm_diode_en});
    @(posedge sys_clk);
    therm_code <= 8'ha5;
    wr(8'h61, 16'hffff);
    rd(8'h61, 16'h00a5, "temperature");
    wr(8'h60, 16'h0000);
    chk("diode", 16'h0000, {15'h0000, therm_diode_en});
    $display("test thermal done");
  endtask

  task automatic t_dark();
    logic [15:0] d;
    for (int e = 0; e < 8; e++) begin
      d = {5'b01000, 3'(e), 8'(8'hf8 + e)};
      wr(8'h80, d);
      chk("dark target", {8'h00, d[7:0]}, {8'h00, dark_target});
      chk("dark exp", 16'(e), {13'h0000, dark_exp});
      @(posedge sys_clk);
      #1;
      chk("dark count", 16'(1 << e), {8'h00, dark_count});
      rd(8'h80, d, "dark word");
    end
    $display("test dark calibration done");
  endtask

  task automatic t_spare();
    wr(8'h50, 16'hffff);
    wr(8'h51, 16'ha5a5);
    wr(8'h46, 16'h1234);
    wr(8'h47, 16'h5555);
    chk("bias", 16'h1234, bias_ref_word);
    rd(8'h50, 16'hffff, "spare a");
    rd(8'h51, 16'ha5a5, "spare b");
    rd(8'h47, 16'h0000, "unmapped");
    rd(8'h70, 16'h0007, "ser power kept");
    // write then read the spare word on back to back edges
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= 8'h51;
    cfg_wdata <= 16'h3c3c;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b1;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    #1;
    chk("spare b back to back", 16'h3c3c, cfg_rdata);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    chk("bias after reset", 16'h8888, bias_ref_word);
    rd(8'h50, 16'h0000, "spare a after reset");
    $display("test spare and reset done");
  endtask

  initial begin
    repeat (3000) @(posedge sys_clk);
    failures++;
    $display("[ERR] watchdog expected finish seen timeout");
    close_out();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_serpow();
    t_pump();
    t_therm();
    t_dark();
    t_spare();
    close_out();
  end
endmodule
`default_nettype wire
